/* rtl/acr_top.v */
// Control/status and result registers of a 10-bit converter.
// Assumes a single-cycle register port and an analog core whose
// comparator and over-range outputs are asynchronous to ref_clk.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps

module acr_top (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Interrupt
  output reg irq,
  // Analog core
  input wire cmp_high_pin,
  input wire over_range_pin,
  output reg converter_power,
  output wire conv_clk,
  output wire sample_hold,
  output wire [9:0] dac_trial,
  output reg [15:0] analog_input_n_sel
);

  `include "acr_map.vh"

  // ==========================================================
  // Declarations
  reg speed_reg;
  reg converter_on_reg;
  reg [3:0] channel_select_reg;
  reg done_reg;
  reg [7:0] result_high_byte_reg;
  reg [1:0] result_low_bits_reg;
  reg [1:0] evt_status_reg;
  reg [1:0] evt_mask_reg;

  reg speed_next;
  reg converter_on_next;
  reg [3:0] channel_select_next;
  reg done_next;
  reg [1:0] evt_status_next;
  reg [1:0] evt_mask_next;
  reg [7:0] rdata_next;

  reg cmp_meta_reg;
  reg cmp_sync_reg;
  reg ovr_meta_reg;
  reg ovr_sync_reg;
  reg step_phase_reg;
  reg step_phase_next;

  wire csr_write;
  wire mask_write;
  wire high_read;
  wire status_read;
  wire chan_change;
  wire sar_restart;
  wire tick;
  wire step;
  wire done_clear;
  wire sar_done;
  wire [9:0] sar_result;

  // One-hot input select, unimplemented inputs never driven
  function [15:0] input_decode;
    input [3:0] chan;
    input on;
    integer i;
    begin
      input_decode = `ACR_SEL_RESET;
      for (i = 0; i < 16; i = i + 1) begin
        if (on && chan == i[3:0] && i < `ACR_NUM_INPUTS) begin
          input_decode[i] = 1'b1;
        end
      end
    end
  endfunction

  // Strobe aimed at one register offset
  function strobe_at;
    input strobe;
    input [7:0] addr;
    input [7:0] offset;
    begin
      strobe_at = strobe && (addr == offset);
    end
  endfunction

  // ==========================================================
  // Access decode
  assign csr_write = strobe_at(reg_wr, reg_addr, `ACR_ADDR_CSR);
  assign mask_write = strobe_at(reg_wr, reg_addr, `ACR_ADDR_EVT_MASK);
  assign high_read = strobe_at(reg_rd, reg_addr, `ACR_ADDR_RES_HI);
  assign status_read = strobe_at(reg_rd, reg_addr, `ACR_ADDR_EVT_STATUS);
  assign done_clear = high_read || csr_write;

  // Abort only matters while a conversion can be running
  assign chan_change = csr_write && converter_on_reg &&
    (reg_wdata[`ACR_CSR_CHAN_MSB:`ACR_CSR_CHAN_LSB] != channel_select_reg);
  assign sar_restart = chan_change;

  // ==========================================================
  // Comparator synchronisers
  // Comparator and over-range come from the analog core, unclocked
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
      ovr_meta_reg <= 1'b0;
      ovr_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= cmp_high_pin;
      cmp_sync_reg <= cmp_meta_reg;
      ovr_meta_reg <= over_range_pin;
      ovr_sync_reg <= ovr_meta_reg;
    end
  end

  // ==========================================================
  // Converter clock and sequencer
  acr_clkdiv u_clkdiv (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .enable(converter_on_reg),
    .speed(speed_reg),
    .tick_reg(tick),
    .conv_clk_reg(conv_clk)
  );

  acr_sar u_sar (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(converter_on_reg),
    .restart(sar_restart),
    .tick(step),
    .cmp_high(cmp_sync_reg),
    .over_range(ovr_sync_reg),
    .sample_reg(sample_hold),
    .trial_reg(dac_trial),
    .result_reg(sar_result),
    .done_reg(sar_done)
  );

  // ==========================================================
  // Trial step pacing
  // A new trial code comes back through the synchroniser three edges
  // later, more than one fast tick: so one step per two ticks, at
  // both speeds, which keeps the conversion length fixed
  always @* begin
    step_phase_next = step_phase_reg;
    if (tick) begin
      step_phase_next = !step_phase_reg;
    end
    if (!converter_on_reg || sar_restart) begin
      step_phase_next = 1'b0;
    end
  end
  assign step = tick && step_phase_reg;

  // ==========================================================
  // Control/status next values
  always @* begin
    speed_next = speed_reg;
    converter_on_next = converter_on_reg;
    channel_select_next = channel_select_reg;
    if (csr_write) begin
      // Done and reserved bits are not writable
      speed_next = reg_wdata[`ACR_CSR_SPEED_BIT];
      converter_on_next = reg_wdata[`ACR_CSR_ON_BIT];
      channel_select_next = reg_wdata[`ACR_CSR_CHAN_MSB:`ACR_CSR_CHAN_LSB];
    end
  end

  // Set beats clear when both land in one cycle
  always @* begin
    done_next = done_reg;
    if (done_clear) begin
      done_next = 1'b0;
    end
    if (sar_done) begin
      done_next = 1'b1;
    end
  end

  // ==========================================================
  // Event status and mask
  // Events stay sticky until software reads the status
  always @* begin
    evt_status_next = evt_status_reg;
    if (status_read) begin
      evt_status_next = `ACR_EVT_RESET;
    end
    if (sar_done) begin
      evt_status_next[`ACR_EVT_DONE_BIT] = 1'b1;
    end
    if (chan_change) begin
      evt_status_next[`ACR_EVT_ABORT_BIT] = 1'b1;
    end
    evt_mask_next = evt_mask_reg;
    if (mask_write) begin
      evt_mask_next = reg_wdata[`ACR_EVT_ABORT_BIT:`ACR_EVT_DONE_BIT];
    end
  end

  // ==========================================================
  // Read mux
  always @* begin
    case (reg_addr)
      `ACR_ADDR_CSR: begin
        rdata_next = `ACR_BYTE_RESET;
        rdata_next[`ACR_CSR_DONE_BIT] = done_reg;
        rdata_next[`ACR_CSR_SPEED_BIT] = speed_reg;
        rdata_next[`ACR_CSR_ON_BIT] = converter_on_reg;
        // Reserved bit stays zero
        rdata_next[`ACR_CSR_CHAN_MSB:`ACR_CSR_CHAN_LSB] = channel_select_reg;
      end
      `ACR_ADDR_RES_HI: begin
        rdata_next = result_high_byte_reg;
      end
      `ACR_ADDR_RES_LO: begin
        rdata_next = `ACR_BYTE_RESET;
        rdata_next[1:0] = result_low_bits_reg;
      end
      `ACR_ADDR_EVT_STATUS: begin
        rdata_next = `ACR_BYTE_RESET;
        rdata_next[`ACR_EVT_ABORT_BIT:`ACR_EVT_DONE_BIT] = evt_status_reg;
      end
      `ACR_ADDR_EVT_MASK: begin
        rdata_next = `ACR_BYTE_RESET;
        rdata_next[`ACR_EVT_ABORT_BIT:`ACR_EVT_DONE_BIT] = evt_mask_reg;
      end
      default: begin
        rdata_next = `ACR_BYTE_RESET;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_reg <= 1'b0;
      converter_on_reg <= 1'b0;
      channel_select_reg <= `ACR_CHAN_RESET;
      done_reg <= 1'b0;
      result_high_byte_reg <= `ACR_BYTE_RESET;
      result_low_bits_reg <= 2'h0;
      evt_status_reg <= `ACR_EVT_RESET;
      evt_mask_reg <= `ACR_EVT_RESET;
      step_phase_reg <= 1'b0;
    end else begin
      speed_reg <= speed_next;
      converter_on_reg <= converter_on_next;
      channel_select_reg <= channel_select_next;
      done_reg <= done_next;
      evt_status_reg <= evt_status_next;
      evt_mask_reg <= evt_mask_next;
      step_phase_reg <= step_phase_next;
      // No latching: a late low-half read may pair with an older high half
      // Port writes never reach the results
      if (sar_done) begin
        result_high_byte_reg <= sar_result[9:2];
        result_low_bits_reg <= sar_result[1:0];
      end
    end
  end

  // ==========================================================
  // Outputs
  // irq, power and input select built from next values so they line up with the registers; reg_rdata comes from the current-value read mux
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `ACR_BYTE_RESET;
      irq <= 1'b0;
      converter_power <= 1'b0;
      analog_input_n_sel <= `ACR_SEL_RESET;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : `ACR_BYTE_RESET;
      irq <= |(evt_status_next & evt_mask_next);
      converter_power <= converter_on_next;
      analog_input_n_sel <= input_decode(channel_select_next, converter_on_next);
    end
  end

endmodule

/* rtl/acr_map.vh */
// Register map, field positions, reset values and timing counts of the
// converter control block. Included by every design file of the block.
`ifndef ACR_MAP_VH
`define ACR_MAP_VH

// ==========================================================
// Register offsets
`define ACR_ADDR_CSR 8'h70
`define ACR_ADDR_RES_HI 8'h71
`define ACR_ADDR_RES_LO 8'h72
`define ACR_ADDR_EVT_STATUS 8'h73
`define ACR_ADDR_EVT_MASK 8'h74

// ==========================================================
// Control/status fields
`define ACR_CSR_DONE_BIT 7
`define ACR_CSR_SPEED_BIT 6
`define ACR_CSR_ON_BIT 5
`define ACR_CSR_RSVD_BIT 4
`define ACR_CSR_CHAN_MSB 3
`define ACR_CSR_CHAN_LSB 0

// ==========================================================
// Event status and mask fields
`define ACR_EVT_DONE_BIT 0
`define ACR_EVT_ABORT_BIT 1

// ==========================================================
// Reset values
`define ACR_BYTE_RESET 8'h00
`define ACR_CHAN_RESET 4'h0
`define ACR_RES_RESET 10'h000
`define ACR_EVT_RESET 2'h0
`define ACR_SEL_RESET 16'h0000

// ==========================================================
// Conversion shape and timing
`define ACR_NUM_INPUTS 16
`define ACR_SAMPLE_TICKS 4'h4
`define ACR_SAR_TOP_BIT 10'h200
`define ACR_RES_FULL 10'h3FF
`define ACR_DIV_LAST_SLOW 2'h3
`define ACR_DIV_LAST_FAST 2'h1

`endif

/* rtl/acr_clkdiv.v */
// Converter clock divider: ref_clk divided by 4 or by 2.
// Assumes speed and enable come from flops on ref_clk.
`timescale 1ns/1ps

module acr_clkdiv (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Control
  input wire enable,
  input wire speed,
  // Converter timing
  output reg tick_reg,
  output reg conv_clk_reg
);

  `include "acr_map.vh"

  reg [1:0] cnt_reg;
  reg [1:0] cnt_next;
  reg [1:0] last;

  // ==========================================================
  // Divider
  always @* begin
    last = speed ? `ACR_DIV_LAST_FAST : `ACR_DIV_LAST_SLOW;
    cnt_next = (cnt_reg == last) ? 2'h0 : cnt_reg + 2'h1;
    if (!enable) begin
      cnt_next = 2'h0;
    end
  end

  // Clock held low while off to save power
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 2'h0;
      tick_reg <= 1'b0;
      conv_clk_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= enable && (cnt_reg == last);
      conv_clk_reg <= enable && (speed ? cnt_next[0] : cnt_next[1]);
    end
  end

endmodule

/* rtl/acr_sar.v */
// Successive approximation sequencer: sample phase, then ten trial steps.
// Assumes cmp_high and over_range are already synchronised to ref_clk.
`timescale 1ns/1ps

module acr_sar (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Control
  input wire run,
  input wire restart,
  input wire tick,
  // Comparator
  input wire cmp_high,
  input wire over_range,
  // Results
  output reg sample_reg,
  output reg [9:0] trial_reg,
  output reg [9:0] result_reg,
  output reg done_reg
);

  `include "acr_map.vh"

  localparam ST_IDLE = 2'b00;
  localparam ST_SAMPLE = 2'b01;
  localparam ST_CONVERT = 2'b10;

  reg [1:0] state_reg;
  reg [3:0] wait_reg;
  reg [9:0] bit_reg;

  // Keep or drop the bit under trial
  function [9:0] resolve;
    input [9:0] trial;
    input [9:0] bitsel;
    input keep;
    begin
      resolve = keep ? trial : (trial & ~bitsel);
    end
  endfunction

  // ==========================================================
  // Sequencer
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      wait_reg <= 4'h0;
      bit_reg <= 10'h000;
      sample_reg <= 1'b0;
      trial_reg <= `ACR_RES_RESET;
      result_reg <= `ACR_RES_RESET;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!run) begin
        state_reg <= ST_IDLE;
        sample_reg <= 1'b0;
        trial_reg <= `ACR_RES_RESET;
      end else if (restart || state_reg == ST_IDLE) begin
        state_reg <= ST_SAMPLE;
        wait_reg <= `ACR_SAMPLE_TICKS;
        sample_reg <= 1'b1;
        trial_reg <= `ACR_RES_RESET;
      end else if (tick) begin
        case (state_reg)
          ST_SAMPLE: begin
            if (wait_reg == 4'h1) begin
              state_reg <= ST_CONVERT;
              sample_reg <= 1'b0;
              bit_reg <= `ACR_SAR_TOP_BIT;
              trial_reg <= `ACR_SAR_TOP_BIT;
            end else begin
              wait_reg <= wait_reg - 4'h1;
            end
          end
          ST_CONVERT: begin
            if (bit_reg[0]) begin
              // Back to sampling at once: continuous mode
              result_reg <= over_range ? `ACR_RES_FULL :
                resolve(trial_reg, bit_reg, cmp_high);
              done_reg <= 1'b1;
              state_reg <= ST_SAMPLE;
              wait_reg <= `ACR_SAMPLE_TICKS;
              sample_reg <= 1'b1;
            end else begin
              trial_reg <= resolve(trial_reg, bit_reg, cmp_high) | (bit_reg >> 1);
              bit_reg <= bit_reg >> 1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* test/acr_analog_model.sv */
// Analog core model: input levels, comparator and over-range flag.
// Assumes the block drives a one-hot select and a registered trial code.
`timescale 1ns/1ps

module acr_analog_model (
  // Clock
  input wire ref_clk,
  // From converter
  input wire converter_power,
  input wire [9:0] dac_trial,
  input wire [15:0] analog_input_n_sel,
  // To converter
  output reg cmp_high_pin,
  output reg over_range_pin
);
  // ==========
  // Input levels, above 3FF means over range
  reg [10:0] level [0:15];
  reg [10:0] lvl;
  reg hit;
  reg idle_reg = 1'b0;
  integer k;

  // Unselected core gives a changing pattern, never a held value
  always @(posedge ref_clk) begin
    idle_reg <= ~idle_reg;
  end

  always @* begin
    hit = 1'b0;
    lvl = 11'h000;
    for (k = 0; k < 16; k = k + 1) begin
      if (analog_input_n_sel[k]) begin
        hit = 1'b1;
        lvl = level[k];
      end
    end
    if (hit && converter_power) begin
      cmp_high_pin = (lvl >= {1'b0, dac_trial});
      over_range_pin = (lvl > 11'h3FF);
    end else begin
      cmp_high_pin = idle_reg;
      over_range_pin = ~idle_reg;
    end
  end
endmodule

/* test/acr_top_asserts.sv */
// Checker of the converter control block, bound to its top module.
// Assumes speed changes only while the converter is off.
`timescale 1ns/1ps
`include "acr_map.vh"

module acr_top_asserts (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Analog core
  input wire converter_power,
  input wire conv_clk,
  input wire sample_hold,
  input wire [15:0] analog_input_n_sel
);
  // ==========
  // Shadow of the speed bit
  reg speed_reg;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `ACR_ADDR_CSR) begin
      speed_reg <= reg_wdata[`ACR_CSR_SPEED_BIT];
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ==========
  // Properties
  a_lo_upper_zero: assert property (
    reg_rd && reg_addr == `ACR_ADDR_RES_LO |=> reg_rdata[7:2] == 6'h00)
    else $error("low result upper bits not zero");
  a_power_follows: assert property (
    reg_wr && reg_addr == `ACR_ADDR_CSR
    |=> converter_power == $past(reg_wdata[`ACR_CSR_ON_BIT]))
    else $error("converter power not following enable bit");
  a_off_no_sel: assert property (
    !converter_power |-> analog_input_n_sel == 16'h0000)
    else $error("input selected while off");
  a_off_idle: assert property (
    !converter_power ##1 !converter_power |-> !sample_hold && !conv_clk)
    else $error("converter active while off");
  a_sel_onehot: assert property ($onehot0(analog_input_n_sel))
    else $error("input select not one-hot");
  a_sel_match: assert property (
    reg_wr && reg_addr == `ACR_ADDR_CSR && reg_wdata[5]
    |=> analog_input_n_sel ==
      (16'h0001 << $past(reg_wdata[`ACR_CSR_CHAN_MSB:`ACR_CSR_CHAN_LSB])))
    else $error("selected input differs from channel field");
  a_slow_clk: assert property (
    $rose(conv_clk) && !speed_reg |=> (conv_clk || !converter_power) ##1 !conv_clk)
    else $error("converter clock not divided by four");
  a_fast_clk: assert property ($rose(conv_clk) && speed_reg |=> !conv_clk)
    else $error("converter clock not divided by two");
  a_sample_start: assert property ($rose(converter_power) |-> ##[0:20] sample_hold)
    else $error("no sample phase after enable");
endmodule

bind acr_top acr_top_asserts chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .converter_power(converter_power), .conv_clk(conv_clk), .sample_hold(sample_hold),
  .analog_input_n_sel(analog_input_n_sel));

/* test/tb_acr_top.sv */
// Bench of the converter control block: register tasks and checks.
// Assumes the analog core model and the block's register map.
`timescale 1ns/1ps
`include "acr_map.vh"

module tb_acr_top;
  // ==========
  // Signals
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire irq, cmp_high_pin, over_range_pin, converter_power, conv_clk, sample_hold;
  wire [9:0] dac_trial;
  wire [15:0] analog_input_n_sel;
  integer errors = 0;
  integer samples_checked = 0;
  integer i;
  reg [7:0] d;
  reg [9:0] e;

  always #25 ref_clk = ~ref_clk;

  acr_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .cmp_high_pin(cmp_high_pin), .over_range_pin(over_range_pin),
    .converter_power(converter_power), .conv_clk(conv_clk), .sample_hold(sample_hold),
    .dac_trial(dac_trial), .analog_input_n_sel(analog_input_n_sel));

  acr_analog_model far (.ref_clk(ref_clk), .converter_power(converter_power),
    .dac_trial(dac_trial), .analog_input_n_sel(analog_input_n_sel),
    .cmp_high_pin(cmp_high_pin), .over_range_pin(over_range_pin));

  // ==========
  // Tasks
  function [9:0] want(input integer ch);
    reg [10:0] lv;
    begin
      lv = far.level[ch];
      want = (lv > 11'h3FF) ? 10'h3FF : lv[9:0];
    end
  endfunction

  task check(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask

  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask

  task rdc(input [7:0] a, input [7:0] exp);
    begin
      rd(a, d);
      check(d, exp);
    end
  endtask

  // Polling does not clear the flag, only a high result read or a control/status write does
  task wait_done;
    integer n;
    begin
      n = 0;
      d = 8'h00;
      while (!d[7] && n < 200) begin
        rd(`ACR_ADDR_CSR, d);
        n = n + 1;
      end
      check(d[7], 1'b1);
    end
  endtask

  task stop_test;
    begin
      if (errors == 0 && samples_checked > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  // ==========
  // Sequence
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      far.level[i] = 11'(i * 64 + 13);
    end
    far.level[5] = 11'h7FF;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      rdc(8'h70 + 8'(i), 8'h00);
    end
    wr(`ACR_ADDR_CSR, 8'h23);
    check(analog_input_n_sel, 16'h0008);
    wait_done;
    e = want(3);
    rdc(`ACR_ADDR_RES_LO, {6'h00, e[1:0]});
    wr(`ACR_ADDR_CSR, 8'hA3);
    rdc(`ACR_ADDR_CSR, 8'h23);
    rdc(`ACR_ADDR_RES_HI, e[9:2]);
    wr(`ACR_ADDR_CSR, 8'h00);
    // Speed changes only while off
    for (i = 0; i < 16; i = i + 1) begin
      wr(`ACR_ADDR_CSR, 8'h60 | 8'(i));
      check(analog_input_n_sel, 16'h0001 << i);
      wait_done;
      e = want(i);
      rdc(`ACR_ADDR_RES_LO, {6'h00, e[1:0]});
      rdc(`ACR_ADDR_RES_HI, e[9:2]);
      rdc(`ACR_ADDR_CSR, 8'h60 | 8'(i));
    end
    check(irq, 1'b0);
    wr(`ACR_ADDR_CSR, 8'h00);
    check(converter_power, 1'b0);
    repeat (200) @(posedge ref_clk);
    rdc(`ACR_ADDR_CSR, 8'h00);
    wr(`ACR_ADDR_RES_HI, 8'h55);
    wr(`ACR_ADDR_RES_LO, 8'hFF);
    rdc(`ACR_ADDR_RES_HI, e[9:2]);
    rdc(`ACR_ADDR_RES_LO, {6'h00, e[1:0]});
    wr(`ACR_ADDR_EVT_MASK, 8'h02);
    @(posedge ref_clk);
    #1;
    check(irq, 1'b1);
    rdc(`ACR_ADDR_EVT_STATUS, 8'h03);
    repeat (2) @(posedge ref_clk);
    #1;
    check(irq, 1'b0);
    rdc(`ACR_ADDR_EVT_STATUS, 8'h00);
    rdc(`ACR_ADDR_EVT_MASK, 8'h02);
    stop_test;
  end

  initial begin
    #(40000 * 50);
    errors = errors + 1;
    stop_test;
  end
endmodule
